/* pkg/iirop_dec_if.sv */
`include "iirop_regs.svh"

interface iirop_dec_if;
  import iirop_pkg::*;
  logic [`IIROP_ADDR_W-1:0] addr;
  logic                     aen;
  logic [7:0]               base_sw;
  logic                     hit;
  iirop_sel_t               sel;

  modport requester (output addr, output aen, output base_sw, input hit, input sel);
  modport decoder   (input addr, input aen, input base_sw, output hit, output sel);
endinterface : iirop_dec_if

/* pkg/iirop_pkg.sv */
`include "iirop_regs.svh"

package iirop_pkg;

  // location selected by the two low address bits
  typedef enum logic [1:0] {
    IIROP_SEL_SENSOR  = `IIROP_OFF_SENSOR,
    IIROP_SEL_SPARE_L = `IIROP_OFF_SPARE_LO,
    IIROP_SEL_RELAY   = `IIROP_OFF_RELAY,
    IIROP_SEL_SPARE_H = `IIROP_OFF_SPARE_HI
  } iirop_sel_t;

  // bus access sequencer, gray along idle -> access -> idle
  typedef enum logic [1:0] {
    IIROP_ST_IDLE  = 2'h0,
    IIROP_ST_READ  = 2'h1,
    IIROP_ST_WRITE = 2'h2
  } iirop_state_t;

  // location code from a full i/o address
  function automatic iirop_sel_t iirop_sel_of(input logic [`IIROP_ADDR_W-1:0] addr);
    iirop_sel_of = iirop_sel_t'(addr[`IIROP_SEL_MSB:`IIROP_SEL_LSB]);
  endfunction : iirop_sel_of

endpackage : iirop_pkg

/* pkg/iirop_regs.svh */
`ifndef IIROP_REGS_SVH
`define IIROP_REGS_SVH

// register offsets within the four-location window
`define IIROP_OFF_SENSOR      2'h0
`define IIROP_OFF_SPARE_LO    2'h1
`define IIROP_OFF_RELAY       2'h2
`define IIROP_OFF_SPARE_HI    2'h3

// address field positions
`define IIROP_ADDR_W          10
`define IIROP_SEL_LSB         0
`define IIROP_SEL_MSB         1
`define IIROP_BASE_LSB        2
`define IIROP_BASE_MSB        9
`define IIROP_PAGE_LSB        8
`define IIROP_PAGE_MSB        9
`define IIROP_PAGE_NONE       2'h0

// data and reset values
`define IIROP_DATA_W          8
`define IIROP_RELAY_RESET     8'h00
`define IIROP_SPARE_READ      8'hFF
`define IIROP_OUT_IDLE        8'h00
`define IIROP_IRQ_LINES       6

// timing
`define IIROP_CLK_MHZ         40
`define IIROP_RELAY_OPERATE_US 500

`endif

/* src/iirop_decode.sv */
`include "iirop_regs.svh"

module iirop_decode
  import iirop_pkg::*;
(
  iirop_dec_if.decoder dec  // address, switch and match result
);

  logic page_ok;
  logic base_eq;

  // window must sit in 100h..3ffh, base bits against switches
  assign page_ok = dec.addr[`IIROP_PAGE_MSB:`IIROP_PAGE_LSB] != `IIROP_PAGE_NONE; // [R07]
  // closed switch reads 0 and matches a 0 address bit
  assign base_eq = dec.addr[`IIROP_BASE_MSB:`IIROP_BASE_LSB] == dec.base_sw; // [R10] [R11]
  assign dec.hit = page_ok && base_eq && !dec.aen;
  // two low bits pick one of four locations
  assign dec.sel = iirop_sel_of(dec.addr); // [R10]

endmodule : iirop_decode

/* src/iirop_port.sv */
`include "iirop_regs.svh"

// Function
// [R01] read at offset zero returns sensor byte; writes there do nothing.
// [R02] sensor bit reads 0 when energised, 1 when undriven.
// [R03] write at offset two latches relay byte; 1 closes a relay.
// [R04] read at offset two returns inverse of the relay latch.
// [R05] offsets one and three decode but carry no function.
// [R06] only the relay location accepts writes.
// [R07] base address selectable within 100h to 3ffh.
// [R08] all transfers are one byte over an 8-bit data path.
// [R09] host must not toggle relays faster than their operate time.
// [R10] four locations: low two bits select, upper bits match base.
// [R11] closed switch matches address 0, open switch matches 1.
// [R12] enabled jumper raises chosen irq when sensor bit zero falls.
// [R13] reset opens all relays until the first host write.
module iirop_port
  import iirop_pkg::*;
#(
  parameter int unsigned OPERATE_CYCLES = `IIROP_RELAY_OPERATE_US * `IIROP_CLK_MHZ
)
(
  input  wire logic                      clk,             // 40 mhz clock
  input  wire logic                      reset,           // sync reset, active high
  input  wire logic [`IIROP_ADDR_W-1:0]  io_addr,         // host i/o address
  input  wire logic                      io_aen,          // dma cycle, high blocks decode
  input  wire logic                      io_rd_n,         // host read strobe
  input  wire logic                      io_wr_n,         // host write strobe
  input  wire logic [7:0]                io_data_in,      // host data bus in
  output logic      [7:0]                io_data_out,     // data bus out
  output logic                           io_data_oe,      // high while driving bus
  input  wire logic [7:0]                sensor_n,        // isolator outputs, low = energised
  input  wire logic [7:0]                base_address_switch, // closed switch = 0
  input  wire logic [5:0]                interrupt_select_jumper, // one-hot irq 2..7
  output logic      [7:0]                relay_drive,     // bit0 relay_zero .. bit7 relay_seven
  output logic      [5:0]                irq_request,     // irq lines 2..7
  output logic                           relays_settled   // contacts past operate time
);

  localparam int SYNC_W = `IIROP_ADDR_W + 3 + 8 + 8 + 8 + 6;
  localparam int CNT_W  = $clog2(OPERATE_CYCLES + 1);

  logic [SYNC_W-1:0]        meta_reg;
  logic [SYNC_W-1:0]        sync_reg;
  logic [`IIROP_ADDR_W-1:0] addr_s;
  logic                     aen_s;
  logic                     rd_s;
  logic                     wr_s;
  logic [7:0]               data_s;
  logic [7:0]               sensor_s;
  logic [7:0]               switch_s;
  logic [5:0]               jumper_s;
  logic                     bit0_prev_reg;
  iirop_state_t             state_reg;
  iirop_state_t             state_next;
  iirop_sel_t               sel_reg;
  logic [7:0]               relay_reg;
  logic [7:0]               relay_next;
  logic [7:0]               wr_data_reg;
  logic [7:0]               dout_reg;
  logic [7:0]               dout_next;
  logic                     oe_reg;
  logic                     irq_pend_reg;
  logic [5:0]               irq_reg;
  logic [CNT_W-1:0]         settle_reg;
  logic                     settled_reg;
  logic                     rd_start;
  logic                     wr_start;
  logic                     wr_end;
  logic                     bit0_fall;
  logic                     sensor_read;

  iirop_dec_if dec ();
  iirop_decode u_decode (.dec(dec));

  // two-flop synchroniser for every pin input except clk and reset
  always_ff @(posedge clk)
  begin
    meta_reg <= {io_addr, io_aen, ~io_rd_n, ~io_wr_n, io_data_in, sensor_n,
                 base_address_switch, interrupt_select_jumper};
    sync_reg <= meta_reg;
  end

  assign {addr_s, aen_s, rd_s, wr_s, data_s, sensor_s, switch_s, jumper_s} = sync_reg;

  // address match in the decoder
  assign dec.addr    = addr_s;
  assign dec.aen     = aen_s;
  assign dec.base_sw = switch_s; // [R11]

  // access starts only from idle with a matched address
  assign rd_start = (state_reg == IIROP_ST_IDLE) && rd_s && dec.hit;
  assign wr_start = (state_reg == IIROP_ST_IDLE) && wr_s && !rd_s && dec.hit;
  assign wr_end   = (state_reg == IIROP_ST_WRITE) && !wr_s;

  // access sequencer next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      IIROP_ST_IDLE:
      begin
        if (rd_start)
          state_next = IIROP_ST_READ;
        else if (wr_start)
          state_next = IIROP_ST_WRITE;
      end
      IIROP_ST_READ:
      begin
        if (!rd_s)
          state_next = IIROP_ST_IDLE;
      end
      IIROP_ST_WRITE:
      begin
        if (!wr_s)
          state_next = IIROP_ST_IDLE;
      end
      default:
        state_next = IIROP_ST_IDLE;
    endcase
  end

  // sequencer state and captured location
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= IIROP_ST_IDLE;
      sel_reg   <= IIROP_SEL_SENSOR;
    end
    else
    begin
      state_reg <= state_next;
      if (rd_start || wr_start)
        sel_reg <= dec.sel;
    end
  end

  // write data follows the bus until the strobe ends
  always_ff @(posedge clk)
  begin
    if (reset)
      wr_data_reg <= `IIROP_RELAY_RESET;
    else if (wr_start || state_reg == IIROP_ST_WRITE)
      wr_data_reg <= data_s; // [R08]
  end

  // relay latch commits once at strobe end, relay location only
  always_comb
  begin
    relay_next = relay_reg;
    if (wr_end && sel_reg == IIROP_SEL_RELAY) // [R03] [R06]
      relay_next = wr_data_reg;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      relay_reg <= `IIROP_RELAY_RESET; // [R13]
    else
      relay_reg <= relay_next; // [R03]
  end

  // read data by location
  always_comb
  begin
    dout_next = `IIROP_OUT_IDLE;
    unique case (dec.sel)
      IIROP_SEL_SENSOR:  dout_next = sensor_s;    // [R01] [R02]
      IIROP_SEL_RELAY:   dout_next = ~relay_reg;  // [R04]
      IIROP_SEL_SPARE_L: dout_next = `IIROP_SPARE_READ; // [R05]
      IIROP_SEL_SPARE_H: dout_next = `IIROP_SPARE_READ; // [R05]
    endcase
  end

  // bus drive held from decode to strobe release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dout_reg <= `IIROP_OUT_IDLE;
      oe_reg   <= 1'b0;
    end
    else if (rd_start)
    begin
      dout_reg <= dout_next; // [R08]
      oe_reg   <= 1'b1;
    end
    else if (state_reg == IIROP_ST_READ && rd_s)
    begin
      if (sel_reg == IIROP_SEL_SENSOR)
        dout_reg <= sensor_s; // [R01]
    end
    else
    begin
      dout_reg <= `IIROP_OUT_IDLE;
      oe_reg   <= 1'b0;
    end
  end

  // interrupt on falling sensor bit zero, cleared by reading sensors
  assign bit0_fall   = bit0_prev_reg && !sensor_s[0];
  assign sensor_read = rd_start && dec.sel == IIROP_SEL_SENSOR;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bit0_prev_reg <= 1'b1;
      irq_pend_reg  <= 1'b0;
      irq_reg       <= '0;
    end
    else
    begin
      bit0_prev_reg <= sensor_s[0];
      if (bit0_fall) // set wins over clear
        irq_pend_reg <= 1'b1; // [R12]
      else if (sensor_read)
        irq_pend_reg <= 1'b0;
      irq_reg <= (bit0_fall || irq_pend_reg) ? jumper_s : '0; // [R12]
    end
  end

  // contact settle timer restarts on each relay change
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      settle_reg  <= '0;
      settled_reg <= 1'b1;
    end
    else if (relay_next != relay_reg)
    begin
      settle_reg  <= CNT_W'(OPERATE_CYCLES); // [R09]
      settled_reg <= 1'b0;
    end
    else if (settle_reg != '0)
    begin
      settle_reg  <= settle_reg - 1'b1;
      settled_reg <= (settle_reg == CNT_W'(1));
    end
  end

  assign io_data_out    = dout_reg;
  assign io_data_oe     = oe_reg;
  assign relay_drive    = relay_reg;
  assign irq_request    = irq_reg;
  assign relays_settled = settled_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_SENSOR_READ: assert property ( // [R01] [R02]
    rd_start && dec.sel == IIROP_SEL_SENSOR |=> io_data_oe && io_data_out == $past(sensor_s))
    else $error("sensor read returned wrong byte");
  AST_RELAY_INVERT: assert property ( // [R04]
    rd_start && dec.sel == IIROP_SEL_RELAY |=> io_data_out == ~relay_drive)
    else $error("relay readback not inverted");
  AST_WRITE_LATCH: assert property ( // [R03]
    wr_end && sel_reg == IIROP_SEL_RELAY |=> relay_drive == $past(wr_data_reg))
    else $error("relay write not latched");
  AST_NO_OTHER_WRITE: assert property ( // [R06]
    wr_end && sel_reg != IIROP_SEL_RELAY |=> $stable(relay_drive) [*2])
    else $error("write changed state at a non-relay location");
  AST_SPARE_READ: assert property ( // [R05]
    rd_start && dec.sel[0] |=> io_data_oe && io_data_out == `IIROP_SPARE_READ)
    else $error("spare location read wrong");
  AST_RANGE: assert property ( // [R07] [R10] [R11]
    $rose(io_data_oe) |-> $past(rd_s && !aen_s
                                && addr_s[`IIROP_PAGE_MSB:`IIROP_PAGE_LSB] != `IIROP_PAGE_NONE
                                && addr_s[`IIROP_BASE_MSB:`IIROP_BASE_LSB] == switch_s))
    else $error("access outside the selected window");
  AST_DRIVE_HOLD: assert property ( // [R08]
    state_reg == IIROP_ST_READ && rd_s |=> io_data_oe)
    else $error("bus released during read strobe");
  AST_RESET_OPEN: assert property ( // [R13]
    $past(reset) |-> relay_drive == `IIROP_RELAY_RESET && !io_data_oe)
    else $error("relays not open after reset");
  AST_IRQ_RAISE: assert property ( // [R12]
    bit0_fall |=> irq_pend_reg && irq_request == $past(jumper_s))
    else $error("sensor fall did not raise irq");
  AST_SETTLE: assert property ( // [R09]
    relay_next != relay_reg |=> !relays_settled [*3])
    else $error("settled flag high during relay operate time");

  COV_RELAY_WRITE: cover property (wr_end && sel_reg == IIROP_SEL_RELAY);
  COV_SENSOR_READ: cover property (rd_start && dec.sel == IIROP_SEL_SENSOR);
  COV_SPARE_WRITE: cover property (wr_start && dec.sel == IIROP_SEL_SPARE_H);
  COV_IRQ:         cover property (bit0_fall && jumper_s != '0);

endmodule : iirop_port

/* verif/iirop_host_model.sv */
// host cpu on the i/o bus: one byte per strobe, fixed setup and gap
module iirop_host_model
(
  input  wire logic       clk,            // bus clock
  input  wire logic [7:0] rd_data,        // device read data
  input  wire logic       rd_oe,          // device drives data bus
  input  wire logic       relays_settled, // relay contacts settled
  output logic      [9:0] io_addr,        // i/o address
  output logic            io_aen,         // dma cycle flag
  output logic            io_rd_n,        // read strobe
  output logic            io_wr_n,        // write strobe
  output logic      [7:0] io_data_in      // write data
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial
  begin
    io_addr    = 10'h000;
    io_aen     = 1'b0;
    io_rd_n    = 1'b1;
    io_wr_n    = 1'b1;
    io_data_in = 8'h5a;
  end

  // one access, called at a rising edge
  task automatic cycle(input logic [9:0] a, input logic aen, input logic wr,
                       input logic [7:0] d, output logic [7:0] q, output logic oe);
    // before a write, wait up to 64 cycles for the last relay change to operate
    for (int k = 0; k < 64 && wr && !relays_settled; k++) @(posedge clk);
    io_addr <= a;
    io_aen  <= aen;
    repeat (3) @(posedge clk);
    io_data_in <= d;
    if (wr)
      io_wr_n <= 1'b0;
    else
      io_rd_n <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    q  = rd_data;
    oe = rd_oe;
    @(posedge clk);
    io_rd_n <= 1'b1;
    io_wr_n <= 1'b1;
    @(posedge clk);
    io_data_in <= ~d; // released bus no longer shows the byte
    repeat (4) @(posedge clk);
  endtask : cycle
endmodule : iirop_host_model

/* verif/tb.sv */
`include "iirop_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, reset, aen, rd_n, wr_n, oe_pin, settled;
  logic [9:0]  addr;
  logic [7:0]  din, dout, sensor_n, sw, relay;
  logic [5:0]  jumper, irq;
  int          num_errors, n_tests;
  logic [31:0] rnd;
  logic [7:0]  rm, swv, d, q;
  logic [2:0]  m;
  logic [1:0]  off;
  logic        pend, wr, oe, hit, chg;
  logic [8:0]  ev;

  iirop_port #(.OPERATE_CYCLES(8)) u_dut (
    .clk(clk), .reset(reset), .io_addr(addr), .io_aen(aen), .io_rd_n(rd_n),
    .io_wr_n(wr_n), .io_data_in(din), .io_data_out(dout), .io_data_oe(oe_pin),
    .sensor_n(sensor_n), .base_address_switch(sw), .interrupt_select_jumper(jumper),
    .relay_drive(relay), .irq_request(irq), .relays_settled(settled));

  iirop_host_model u_host (
    .clk(clk), .rd_data(dout), .rd_oe(oe_pin), .relays_settled(settled),
    .io_addr(addr), .io_aen(aen), .io_rd_n(rd_n), .io_wr_n(wr_n), .io_data_in(din));

  // 40 mhz clock
  always #12.5 clk = ~clk;

  // pseudo-random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // compare and count
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // counts, verdict, end of run
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  // reset, then random accesses against the byte model
  initial
  begin
    clk        = 1'b0;
    reset      = 1'b1;
    sensor_n   = 8'hff;
    sw         = 8'hc0;
    jumper     = 6'h00;
    rnd        = 32'h0000_21a3;
    rm         = 8'h00;
    pend       = 1'b0;
    num_errors = 0;
    n_tests    = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    chk({settled, relay}, 9'h100);
    for (int i = 0; i < 48; i++)
    begin
      chk({3'b000, irq}, {3'b000, jumper & {6{pend}}});
      rnd = lfsr_next(lfsr_next(rnd));
      m   = rnd[29:27];
      off = rnd[17:16];
      wr  = rnd[18];
      d   = rnd[26:19];
      hit = (m > 3'h2);
      if (sensor_n[0] && !rnd[0])
        pend = 1'b1;
      swv = {(m == 3'h2) ? 2'b00 : ((rnd[15:14] == 2'b00) ? 2'b11 : rnd[15:14]), rnd[13:8]};
      sensor_n <= rnd[7:0];
      sw       <= swv;
      jumper   <= (rnd[2:0] > 3'h5) ? 6'h00 : (6'h01 << rnd[2:0]);
      u_host.cycle({(m == 3'h1) ? (swv ^ 8'h10) : swv, off}, m == 3'h0, wr, d, q, oe);
      if (wr)
      begin
        // a relay change restarts the operate timer
        chg = hit && off == `IIROP_OFF_RELAY && d != rm;
        if (hit && off == `IIROP_OFF_RELAY)
          rm = d;
        chk({settled, relay}, {!chg, rm});
      end
      else
      begin
        // expected byte by location
        ev = {1'b1, (off == `IIROP_OFF_RELAY) ? ~rm : 8'hff};
        if (off == `IIROP_OFF_SENSOR)
          ev = {1'b1, rnd[7:0]};
        chk({oe, q}, hit ? ev : 9'h000);
        if (hit && off == `IIROP_OFF_SENSOR)
          pend = 1'b0;
      end
    end
    chk({3'b000, irq}, {3'b000, jumper & {6{pend}}});
    print_verdict();
  end
endmodule : tb
